/* File: rtl/spl_pkg.sv */
// Package of constants and types for the serial port block.
package spl_pkg;

    // ------------------------------------------------------------
    // Register map and reset values
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_CTRL   = 8'h00;
    localparam logic [7:0] OFS_DATA   = 8'h04;
    localparam logic [7:0] OFS_PWR    = 8'h08;
    localparam logic [7:0] OFS_ADDR   = 8'h0c;
    localparam logic [7:0] OFS_BCAST  = 8'h10;
    localparam logic [7:0] OFS_ISTAT  = 8'h14;
    localparam logic [7:0] OFS_IMASK  = 8'h18;

    localparam logic [7:0] CTRL_RST   = 8'h00;
    localparam logic [1:0] PWR_RST    = 2'h0;
    localparam logic [7:0] ADDR_RST   = 8'h00;
    localparam logic [7:0] BCAST_RST  = 8'hff;
    localparam logic [7:0] DATA_RST   = 8'h00;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int PWR_RD_BIT  = 7;
    localparam int PWR_EAS_BIT = 6;
    localparam int CTRL_FE_BIT = 7;

    localparam int IRQ_W      = 3;
    localparam int IRQ_TX_BIT = 0;
    localparam int IRQ_RX_BIT = 1;
    localparam int IRQ_FE_BIT = 2;
    localparam logic [IRQ_W-1:0] IRQ_RST = 3'h0;

    // ------------------------------------------------------------
    // Timing counts
    // ------------------------------------------------------------
    localparam int BAUD_DIV = 2;
    localparam logic [3:0] OVS_MID   = 4'h7;
    localparam logic [3:0] OVS_LAST  = 4'hf;
    localparam logic [3:0] SHIFT_LAST = 4'h7;
    localparam logic [3:0] LAST8     = 4'h8;
    localparam logic [3:0] LAST9     = 4'h9;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        MODE_SHIFT  = 2'h0,
        MODE_UART8  = 2'h1,
        MODE_UART9F = 2'h2,
        MODE_UART9T = 2'h3
    } spl_mode_e;

    typedef enum logic [1:0] {
        TX_IDLE  = 2'h0,
        TX_SHIFT = 2'h1,
        TX_STOP  = 2'h3
    } spl_tx_e;

    typedef enum logic [1:0] {
        RX_IDLE  = 2'h0,
        RX_START = 2'h1,
        RX_DATA  = 2'h3,
        RX_STOP  = 2'h2
    } spl_rx_e;

    typedef struct packed {
        logic serial_mode_high;
        logic serial_mode_low;
        logic multiproc_filter_enable;
        logic rx_enable;
        logic tx_ninth_bit;
        logic rx_ninth_bit;
        logic tx_done_flag;
        logic rx_done_flag;
    } spl_ctrl_s;

endpackage

/* File: rtl/spl_baud.sv */
// Shift tick divider for the serial port.
`timescale 1ns/1ps

module spl_baud #(
    parameter int DIV = spl_pkg::BAUD_DIV
) (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic src_tick,
    input  wire logic rate_double,
    output logic      tick
);

    // ------------------------------------------------------------
    // Divider
    // ------------------------------------------------------------
    // Doubling the rate bypasses the divider.
    logic [1:0] cnt_ff;
    logic [1:0] nxt_cnt;
    wire        last = rate_double || (cnt_ff == 2'(DIV - 1));

    assign tick = src_tick & last;

    always_comb
    begin
        nxt_cnt = cnt_ff;
        if (src_tick)
            nxt_cnt = last ? 2'h0 : cnt_ff + 2'h1;
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            cnt_ff <= 2'h0;
        else
            cnt_ff <= nxt_cnt;
    end

endmodule // spl_baud

/* File: rtl/spl_serial.sv */
// Serial port: control register, framing, rate select, APB slave.
// Operation
// - Mode code 0 shift register, 1 UART8, 2 UART9 fixed, 3 UART9 timer.
// - 9-bit filter: done only if ninth bit is 1 and address matches.
// - 8-bit filter: done only with valid stop bit and address match.
// - Shift mode clock idles at inverse of the filter bit.
// - Receive only while receive enable is set by software.
// - 9-bit modes store received ninth bit in rx ninth-bit field.
// - 8-bit mode, filter off: store stop bit in rx ninth-bit field.
// - Shift mode leaves rx ninth-bit field untouched.
// - Tx done at eighth bit end (shift) or stop start; software clears.
// - Rx done at eighth bit end (shift) or mid stop; software clears.
// - Shift mode rate is clock/4, or clock/2 with rate double; the code uses timer ticks instead when the tx ninth bit is set.
// - Fixed 9-bit rate is clock/32, or clock/16 with rate double.
// - 8-bit frame: zero start, eight data LSB first, one stop.
// - 9-bit frame adds tx ninth bit; received stop plays no part in acceptance.
// - Data write starts tx; UART rx starts on start bit if enabled.
// - Bad stop sets frame error; bit 7 shows it when selected.
//
// Implementation choices: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps

module spl_serial (
    input  wire logic       SYS_CLK,
    input  wire logic       RST_N,
    input  wire logic       PSEL,
    input  wire logic       PENABLE,
    input  wire logic       PWRITE,
    input  wire logic [7:0] PADDR,
    input  wire logic [31:0] PWDATA,
    output logic [31:0]     PRDATA,
    output logic            PREADY,
    output logic            PSLVERR,
    input  wire logic       BAUD_TICK,
    output logic            TXD,
    input  wire logic       RXD_I,
    output logic            RXD_O,
    output logic            RXD_OE,
    output logic            IRQ
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    spl_pkg::spl_ctrl_s ctrl_ff, nxt_ctrl;
    logic               fe_ff, nxt_fe;
    logic [1:0]         pwr_ff;
    logic [7:0]         addr_ff;
    logic [7:0]         bcast_ff;
    logic [7:0]         rbuf_ff;
    logic [2:0]         istat_ff, nxt_istat;
    logic [2:0]         imask_ff;
    logic [31:0]        prdata_ff;
    spl_pkg::spl_tx_e   tx_st_ff, nxt_tx_st;
    logic [3:0]         tx_idx_ff, nxt_tx_idx;
    logic [3:0]         tx_ovs_ff, nxt_tx_ovs;
    logic [8:0]         tx_sh_ff, nxt_tx_sh;
    spl_pkg::spl_rx_e   rx_st_ff, nxt_rx_st;
    logic [3:0]         rx_idx_ff, nxt_rx_idx;
    logic [3:0]         rx_ovs_ff, nxt_rx_ovs;
    logic [8:0]         rx_sh_ff, nxt_rx_sh;
    logic               rxd_prev_ff;
    logic               txd_ff, nxt_txd;
    logic               rxd_o_ff;
    logic               rxd_oe_ff;
    logic               tx_ev;
    logic               rx_ev;
    logic               fe_ev;
    logic               rb8_ev;
    logic               rb8_val;
    logic [7:0]         rx_byte;

    // ------------------------------------------------------------
    // Mode decode
    // ------------------------------------------------------------
    spl_pkg::spl_mode_e mode;
    assign mode = spl_pkg::spl_mode_e'({ctrl_ff.serial_mode_high,
                                        ctrl_ff.serial_mode_low});
    wire mode0 = (mode == spl_pkg::MODE_SHIFT);
    wire mode1 = (mode == spl_pkg::MODE_UART8);
    wire nine  = ctrl_ff.serial_mode_high;
    wire sm2   = ctrl_ff.multiproc_filter_enable;
    wire rdbl  = pwr_ff[1];
    wire eas   = pwr_ff[0];
    // Timer ticks drive modes 1 and 3, and mode 0 with the ninth bit set.
    wire use_timer = mode1 || (mode == spl_pkg::MODE_UART9T) ||
                     (mode0 && ctrl_ff.tx_ninth_bit);
    wire tick;

    // One tick is half a bit in mode 0 and a
    // sixteenth of a bit in the UART modes.
    spl_baud #(
        .DIV         (spl_pkg::BAUD_DIV)
    ) u_baud (
        .clk         (SYS_CLK),
        .rst_n       (RST_N),
        .src_tick    (use_timer ? BAUD_TICK : 1'b1),
        .rate_double (rdbl),
        .tick        (tick)
    );

    // ------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------
    wire setup    = PSEL & ~PENABLE;
    wire access   = PSEL & PENABLE;
    wire wr       = access & PWRITE;
    wire hit_ctrl = (PADDR == spl_pkg::OFS_CTRL);
    wire hit_data = (PADDR == spl_pkg::OFS_DATA);
    wire hit_pwr  = (PADDR == spl_pkg::OFS_PWR);
    wire hit_addr = (PADDR == spl_pkg::OFS_ADDR);
    wire hit_bc   = (PADDR == spl_pkg::OFS_BCAST);
    wire hit_ist  = (PADDR == spl_pkg::OFS_ISTAT);
    wire hit_imk  = (PADDR == spl_pkg::OFS_IMASK);
    wire mapped   = hit_ctrl | hit_data | hit_pwr | hit_addr |
                    hit_bc | hit_ist | hit_imk;
    wire wr_ctrl  = wr & hit_ctrl;
    wire wr_data  = wr & hit_data;

    // Bit 7 of the control word is the error flag when selected.
    wire [7:0] ctrl_rd = {eas ? fe_ff : ctrl_ff.serial_mode_high,
                          ctrl_ff[6:0]};
    wire [7:0] pwr_rd  = {rdbl, eas, 6'h00};

    wire [31:0] rd_data =
        hit_ctrl ? {24'h0, ctrl_rd} :
        hit_data ? {24'h0, rbuf_ff} :
        hit_pwr  ? {24'h0, pwr_rd} :
        hit_addr ? {24'h0, addr_ff} :
        hit_bc   ? {24'h0, bcast_ff} :
        hit_ist  ? {29'h0, istat_ff} :
        hit_imk  ? {29'h0, imask_ff} : 32'h0;

    assign PREADY  = 1'b1;
    assign PSLVERR = access & ~mapped;
    assign PRDATA  = prdata_ff;
    assign IRQ     = |(istat_ff & imask_ff);

    // ------------------------------------------------------------
    // Control register
    // ------------------------------------------------------------
    // A hardware set beats a same-cycle software clear,
    // so no event is lost.
    always_comb
    begin
        nxt_ctrl = ctrl_ff;
        nxt_fe   = fe_ff;
        if (wr_ctrl)
        begin
            nxt_ctrl = spl_pkg::spl_ctrl_s'(PWDATA[7:0]);
            if (eas)
            begin
                nxt_ctrl.serial_mode_high = ctrl_ff.serial_mode_high;
                nxt_fe = PWDATA[spl_pkg::CTRL_FE_BIT];
            end
        end
        if (tx_ev)
            nxt_ctrl.tx_done_flag = 1'b1;
        if (rx_ev)
            nxt_ctrl.rx_done_flag = 1'b1;
        if (rb8_ev)
            nxt_ctrl.rx_ninth_bit = rb8_val;
        if (fe_ev)
            nxt_fe = 1'b1;
    end

    always_comb
    begin
        nxt_istat = istat_ff;
        if (wr & hit_ist)
            nxt_istat = istat_ff & ~PWDATA[2:0];
        nxt_istat[spl_pkg::IRQ_TX_BIT] =
            nxt_istat[spl_pkg::IRQ_TX_BIT] | tx_ev;
        nxt_istat[spl_pkg::IRQ_RX_BIT] =
            nxt_istat[spl_pkg::IRQ_RX_BIT] | rx_ev;
        nxt_istat[spl_pkg::IRQ_FE_BIT] =
            nxt_istat[spl_pkg::IRQ_FE_BIT] | fe_ev;
    end

    // ------------------------------------------------------------
    // Transmitter
    // ------------------------------------------------------------
    wire [3:0] tx_last = nine ? spl_pkg::LAST9 : spl_pkg::LAST8;
    wire tx_end = tick & (mode0 ? tx_ovs_ff[0] :
                          (tx_ovs_ff == spl_pkg::OVS_LAST));

    always_comb
    begin
        nxt_tx_st  = tx_st_ff;
        nxt_tx_idx = tx_idx_ff;
        nxt_tx_ovs = tx_ovs_ff;
        nxt_tx_sh  = tx_sh_ff;
        tx_ev      = 1'b0;
        case (tx_st_ff)
            spl_pkg::TX_IDLE:
            begin
                // A write while busy is dropped, not queued.
                if (wr_data)
                begin
                    nxt_tx_sh  = {ctrl_ff.tx_ninth_bit, PWDATA[7:0]};
                    nxt_tx_idx = 4'h0;
                    nxt_tx_ovs = 4'h0;
                    nxt_tx_st  = spl_pkg::TX_SHIFT;
                end
            end
            spl_pkg::TX_SHIFT:
            begin
                if (tick)
                    nxt_tx_ovs = tx_ovs_ff + 4'h1;
                if (tx_end)
                begin
                    nxt_tx_ovs = 4'h0;
                    nxt_tx_idx = tx_idx_ff + 4'h1;
                    if (mode0 || tx_idx_ff != 4'h0)
                        nxt_tx_sh = {1'b0, tx_sh_ff[8:1]};
                    if (mode0 && tx_idx_ff == spl_pkg::SHIFT_LAST)
                    begin
                        tx_ev     = 1'b1;
                        nxt_tx_st = spl_pkg::TX_IDLE;
                    end
                    else if (!mode0 && tx_idx_ff == tx_last)
                    begin
                        tx_ev     = 1'b1;
                        nxt_tx_st = spl_pkg::TX_STOP;
                    end
                end
            end
            spl_pkg::TX_STOP:
            begin
                if (tick)
                    nxt_tx_ovs = tx_ovs_ff + 4'h1;
                if (tx_end)
                    nxt_tx_st = spl_pkg::TX_IDLE;
            end
            default:
                nxt_tx_st = spl_pkg::TX_IDLE;
        endcase
    end

    // ------------------------------------------------------------
    // Receiver
    // ------------------------------------------------------------
    wire [3:0] rx_last = mode0 ? spl_pkg::SHIFT_LAST :
                         (nine ? spl_pkg::LAST8 : spl_pkg::SHIFT_LAST);
    wire rx_mid = tick & (mode0 ? rx_ovs_ff[0] :
                          (rx_ovs_ff == spl_pkg::OVS_MID));
    wire rx_end = tick & (mode0 ? rx_ovs_ff[0] :
                          (rx_ovs_ff == spl_pkg::OVS_LAST));
    wire [8:0] rx_shifted = {RXD_I, rx_sh_ff[8:1]};
    wire [7:0] uart_byte  = nine ? rx_sh_ff[7:0] : rx_sh_ff[8:1];
    wire ninth = rx_sh_ff[8];
    wire match = (uart_byte == addr_ff) || (uart_byte == bcast_ff);
    wire ok9 = !sm2 || (ninth && match);
    wire ok8 = !sm2 || (RXD_I && match);

    always_comb
    begin
        nxt_rx_st  = rx_st_ff;
        nxt_rx_idx = rx_idx_ff;
        nxt_rx_ovs = rx_ovs_ff;
        nxt_rx_sh  = rx_sh_ff;
        rx_ev      = 1'b0;
        fe_ev      = 1'b0;
        rb8_ev     = 1'b0;
        rb8_val    = 1'b0;
        rx_byte    = uart_byte;
        case (rx_st_ff)
            spl_pkg::RX_IDLE:
            begin
                nxt_rx_ovs = 4'h0;
                nxt_rx_idx = 4'h0;
                if (ctrl_ff.rx_enable && mode0 &&
                    !ctrl_ff.rx_done_flag)
                    nxt_rx_st = spl_pkg::RX_DATA;
                else if (ctrl_ff.rx_enable && !mode0 &&
                         rxd_prev_ff && !RXD_I)
                    nxt_rx_st = spl_pkg::RX_START;
            end
            spl_pkg::RX_START:
            begin
                if (tick)
                    nxt_rx_ovs = rx_ovs_ff + 4'h1;
                if (rx_mid && RXD_I)
                    nxt_rx_st = spl_pkg::RX_IDLE;
                else if (rx_end)
                begin
                    nxt_rx_ovs = 4'h0;
                    nxt_rx_st  = spl_pkg::RX_DATA;
                end
            end
            spl_pkg::RX_DATA:
            begin
                if (tick)
                    nxt_rx_ovs = rx_ovs_ff + 4'h1;
                if (rx_mid)
                    nxt_rx_sh = rx_shifted;
                if (rx_end)
                begin
                    nxt_rx_ovs = 4'h0;
                    nxt_rx_idx = rx_idx_ff + 4'h1;
                    if (rx_idx_ff == rx_last)
                    begin
                        if (mode0)
                        begin
                            // Ninth-bit field is left alone here.
                            rx_byte   = rx_shifted[8:1];
                            rx_ev     = 1'b1;
                            nxt_rx_st = spl_pkg::RX_IDLE;
                        end
                        else
                            nxt_rx_st = spl_pkg::RX_STOP;
                    end
                end
            end
            spl_pkg::RX_STOP:
            begin
                if (tick)
                    nxt_rx_ovs = rx_ovs_ff + 4'h1;
                if (rx_mid)
                begin
                    nxt_rx_st = spl_pkg::RX_IDLE;
                    fe_ev     = !RXD_I;
                    if (nine)
                    begin
                        // Stop bit plays no part in acceptance.
                        rx_ev   = ok9;
                        rb8_ev  = ok9;
                        rb8_val = ninth;
                    end
                    else
                    begin
                        rx_ev   = ok8;
                        rb8_ev  = ok8 && !sm2;
                        rb8_val = RXD_I;
                    end
                end
            end
            default:
                nxt_rx_st = spl_pkg::RX_IDLE;
        endcase
        // Clearing the enable drops a frame in flight.
        if (!ctrl_ff.rx_enable)
            nxt_rx_st = spl_pkg::RX_IDLE;
    end

    // ------------------------------------------------------------
    // Line drive
    // ------------------------------------------------------------
    wire tx_busy  = (tx_st_ff != spl_pkg::TX_IDLE);
    wire rx0_busy = mode0 && (rx_st_ff == spl_pkg::RX_DATA);
    wire phase    = tx_busy ? tx_ovs_ff[0] : rx_ovs_ff[0];

    always_comb
    begin
        if (mode0)
            nxt_txd = (tx_busy || rx0_busy) ? (phase ? ~sm2 : sm2)
                                            : ~sm2;
        else if (tx_st_ff == spl_pkg::TX_SHIFT)
            nxt_txd = (tx_idx_ff == 4'h0) ? 1'b0 : tx_sh_ff[0];
        else
            nxt_txd = 1'b1;
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge SYS_CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            ctrl_ff  <= spl_pkg::spl_ctrl_s'(spl_pkg::CTRL_RST);
            fe_ff    <= 1'b0;
            pwr_ff   <= spl_pkg::PWR_RST;
            addr_ff  <= spl_pkg::ADDR_RST;
            bcast_ff <= spl_pkg::BCAST_RST;
            rbuf_ff  <= spl_pkg::DATA_RST;
            istat_ff <= spl_pkg::IRQ_RST;
            imask_ff <= spl_pkg::IRQ_RST;
            prdata_ff <= 32'h0;
        end
        else
        begin
            ctrl_ff  <= nxt_ctrl;
            fe_ff    <= nxt_fe;
            istat_ff <= nxt_istat;
            if (wr & hit_pwr)
                pwr_ff <= {PWDATA[spl_pkg::PWR_RD_BIT],
                           PWDATA[spl_pkg::PWR_EAS_BIT]};
            if (wr & hit_addr)
                addr_ff <= PWDATA[7:0];
            if (wr & hit_bc)
                bcast_ff <= PWDATA[7:0];
            if (wr & hit_imk)
                imask_ff <= PWDATA[2:0];
            if (rx_ev)
                rbuf_ff <= rx_byte;
            if (setup)
                prdata_ff <= rd_data;
        end
    end

    always_ff @(posedge SYS_CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            tx_st_ff    <= spl_pkg::TX_IDLE;
            tx_idx_ff   <= 4'h0;
            tx_ovs_ff   <= 4'h0;
            tx_sh_ff    <= 9'h000;
            rx_st_ff    <= spl_pkg::RX_IDLE;
            rx_idx_ff   <= 4'h0;
            rx_ovs_ff   <= 4'h0;
            rx_sh_ff    <= 9'h000;
            rxd_prev_ff <= 1'b1;
        end
        else
        begin
            tx_st_ff    <= nxt_tx_st;
            tx_idx_ff   <= nxt_tx_idx;
            tx_ovs_ff   <= nxt_tx_ovs;
            tx_sh_ff    <= nxt_tx_sh;
            rx_st_ff    <= nxt_rx_st;
            rx_idx_ff   <= nxt_rx_idx;
            rx_ovs_ff   <= nxt_rx_ovs;
            rx_sh_ff    <= nxt_rx_sh;
            rxd_prev_ff <= RXD_I;
        end
    end

    // Registered pins keep decode glitches off the line.
    always_ff @(posedge SYS_CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            txd_ff    <= 1'b1;
            rxd_o_ff  <= 1'b1;
            rxd_oe_ff <= 1'b0;
        end
        else
        begin
            txd_ff    <= nxt_txd;
            rxd_o_ff  <= tx_sh_ff[0];
            rxd_oe_ff <= mode0 & tx_busy;
        end
    end

    assign TXD    = txd_ff;
    assign RXD_O  = rxd_o_ff;
    assign RXD_OE = rxd_oe_ff;

endmodule // spl_serial

/* File: testbench/spl_serial_properties.sv */
// Port-level checker for the serial port.
`timescale 1ns/1ps

module spl_serial_props (
    input wire logic        SYS_CLK,
    input wire logic        RST_N,
    input wire logic        PSEL,
    input wire logic        PENABLE,
    input wire logic        PWRITE,
    input wire logic [7:0]  PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic [31:0] PRDATA,
    input wire logic        PREADY,
    input wire logic        PSLVERR,
    input wire logic        TXD,
    input wire logic        RXD_OE,
    input wire logic        IRQ
);
    // Shadow of mode and rate bits.
    logic [7:0]  ctrl_ff;
    logic [7:0]  pwr_ff;
    logic [15:0] low_ff;
    wire         acc    = PSEL && PENABLE && PREADY;
    wire         wr     = acc && PWRITE;
    wire         mode2  = ctrl_ff[7:6] == 2'h2;
    wire         idle0  = ctrl_ff[7:6] == 2'h0 && !ctrl_ff[4];
    wire         unmap  = PADDR > spl_pkg::OFS_IMASK || PADDR[1:0] != 2'h0;
    wire  [15:0] bitlen = pwr_ff[7] ? 16'h0010 : 16'h0020;

    always_ff @(posedge SYS_CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            ctrl_ff <= 8'h00;
            pwr_ff  <= 8'h00;
            low_ff  <= 16'h0000;
        end
        else
        begin
            if (wr && PADDR == spl_pkg::OFS_CTRL)
                ctrl_ff <= {pwr_ff[6] ? ctrl_ff[7] : PWDATA[7], PWDATA[6:0]};
            if (wr && PADDR == spl_pkg::OFS_PWR)
                pwr_ff <= PWDATA[7:0];
            low_ff <= TXD ? 16'h0000 : low_ff + 16'h0001;
        end
    end

    // ----------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------
    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (!RST_N);

    a_ready_high: assert property (PREADY)
        else $error("ready low");
    a_err_unmapped: assert property
        (acc && PADDR > spl_pkg::OFS_IMASK |-> PSLVERR)
        else $error("no error on unmapped access");
    a_err_cause: assert property (PSLVERR |-> acc && unmap)
        else $error("spurious error response");
    a_read_upper: assert property (acc && !PWRITE |-> PRDATA[31:8] == 24'h0)
        else $error("upper read bits set");
    a_unmap_zero: assert property
        (acc && !PWRITE && PSLVERR |-> PRDATA == 32'h0)
        else $error("unmapped read not zero");
    a_mask_quiet: assert property (wr && PADDR == spl_pkg::OFS_IMASK
        && PWDATA[2:0] == 3'h0 |=> !IRQ)
        else $error("interrupt with empty mask");
    a_idle_clock: assert property (idle0 && $stable(ctrl_ff) && !RXD_OE
        && !$past(RXD_OE) && !$past(RXD_OE, 2) |-> TXD == !ctrl_ff[5])
        else $error("shift clock idle level wrong");
    a_bit_time: assert property (mode2 && $rose(TXD)
        |-> low_ff % bitlen == 16'h0)
        else $error("fixed mode bit time wrong");
    a_oe_shift: assert property (RXD_OE |-> ctrl_ff[7:6] == 2'h0)
        else $error("data pin driven outside shift mode");
endmodule // spl_serial_props

bind spl_serial spl_serial_props spl_serial_props_inst (.*);

/* File: testbench/spl_remote.sv */
// Remote serial node: sends and decodes frames.
`timescale 1ns/1ps

module spl_remote (
    input  wire logic        clk,
    input  wire logic        txd,
    input  wire logic        on,
    input  wire logic [15:0] bit_cyc,
    input  wire logic [3:0]  nbits,
    output logic             rxd,
    output logic [10:0]      got,
    output logic             stb
);
    initial
    begin
        rxd = 1'b1;
        stb = 1'b0;
        got = '0;
    end

    // Samples mid-bit without resync.
    always
    begin
        @(negedge txd);
        if (on)
        begin
            repeat (bit_cyc / 2) @(posedge clk);
            got <= '0;
            for (int i = 0; i < nbits; i++)
            begin
                got[i] <= txd;
                repeat (bit_cyc) @(posedge clk);
            end
            stb <= 1'b1;
            @(posedge clk);
            stb <= 1'b0;
        end
    end

    task automatic send(input logic [10:0] f, input int n);
        for (int i = 0; i < n; i++)
        begin
            rxd <= f[i];
            repeat (bit_cyc) @(posedge clk);
        end
        rxd <= 1'b1;
        repeat (bit_cyc) @(posedge clk);
    endtask
endmodule // spl_remote

/* File: testbench/tb_top.sv */
// Self-checking bench for the serial port.
`timescale 1ns/1ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin errors++; \
    $display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); end end

module tb_top;
    logic        SYS_CLK = 0, RST_N = 1, PSEL = 0, PENABLE = 0, PWRITE = 0;
    logic        BAUD_TICK = 0, on = 1;
    logic [7:0]  PADDR = '0, d, c;
    logic [31:0] PWDATA = '0, PRDATA, e32;
    logic        PREADY, PSLVERR, TXD, RXD_I, RXD_O, RXD_OE, IRQ, stb;
    logic [10:0] got, e11;
    logic [15:0] bc = 16'h0010;
    logic [3:0]  nb = 4'hb;
    int          errors = 0, tests_run = 0, cyc = 0;
    logic [31:0] rq[$];
    logic [10:0] fq[$];

    always #4 SYS_CLK = ~SYS_CLK;
    always @(posedge SYS_CLK) BAUD_TICK <= ~BAUD_TICK;

    spl_serial spl_serial_inst (.*);
    spl_remote spl_remote_inst (.clk(SYS_CLK), .txd(TXD), .on(on),
        .bit_cyc(bc), .nbits(nb), .rxd(RXD_I), .got(got), .stb(stb));

    always @(posedge SYS_CLK)
    begin
        if (PSEL && PENABLE && !PWRITE && PREADY === 1'b1)
        begin
            e32 = rq.pop_front();
            `CHK(PRDATA, e32)
        end
        if (stb === 1'b1)
        begin
            e11 = fq.pop_front();
            `CHK(got, e11)
        end
        cyc++;
        if (cyc == 60000)
        begin
            errors++;
            print_verdict();
        end
    end

    task automatic apb(input logic w, input logic [7:0] a, v);
        @(posedge SYS_CLK);
        PSEL   <= 1'b1;
        PWRITE <= w;
        PADDR  <= a;
        PWDATA <= {24'h0, v};
        @(posedge SYS_CLK);
        PENABLE <= 1'b1;
        do @(posedge SYS_CLK); while (PREADY !== 1'b1);
        PSEL    <= 1'b0;
        PENABLE <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, e);
        rq.push_back({24'h0, e});
        apb(1'b0, a, 8'h00);
    endtask

    task automatic tx(input logic [7:0] c, p, input int b, n);
        apb(1'b1, spl_pkg::OFS_PWR, p);
        apb(1'b1, spl_pkg::OFS_CTRL, c);
        bc = 16'(b);
        nb = 4'(n);
        d = 8'($urandom);
        fq.push_back(n == 11 ? {1'b1, c[3], d, 1'b0} : {2'b01, d, 1'b0});
        apb(1'b1, spl_pkg::OFS_DATA, d);
        wait (stb === 1'b1);
        rd(spl_pkg::OFS_CTRL, c | 8'h02);
        rd(spl_pkg::OFS_ISTAT, 8'h01);
        @(negedge SYS_CLK);
        `CHK(IRQ, 1'b1)
        apb(1'b1, spl_pkg::OFS_ISTAT, 8'h01);
        apb(1'b1, spl_pkg::OFS_CTRL, c);
        @(negedge SYS_CLK);
        `CHK(IRQ, 1'b0)
        rd(spl_pkg::OFS_CTRL, c);
    endtask

    task automatic rx(input logic [7:0] c, input logic [10:0] f,
                      input int n, input logic [7:0] e);
        apb(1'b1, spl_pkg::OFS_CTRL, c);
        spl_remote_inst.send(f, n);
        rd(spl_pkg::OFS_CTRL, e);
        if (e[0])
            rd(spl_pkg::OFS_DATA, f[8:1]);
    endtask

    task automatic print_verdict();
        if (errors == 0 && tests_run > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    initial
    begin
        RST_N <= 1'b0;
        d = 8'($urandom(32'ha1be));
        repeat (2) @(posedge SYS_CLK);
        RST_N <= 1'b1;
        for (int i = 0; i < 8; i++)
            rd(8'(i * 4), i == 4 ? spl_pkg::BCAST_RST : 8'h00);
        apb(1'b1, spl_pkg::OFS_IMASK, 8'h01);
        for (int i = 0; i < 6; i++)
        begin
            c = {2'(i / 2 + 1), 3'h0, 1'($urandom), 2'h0};
            tx(c, {1'(i % 2), 7'h00}, (i / 2 == 1 ? 32 : 64) >> (i % 2),
               i < 2 ? 10 : 11);
        end
        apb(1'b1, spl_pkg::OFS_PWR, 8'h80);
        apb(1'b1, spl_pkg::OFS_ADDR, 8'h5a);
        bc = 16'h0010;
        d = 8'($urandom);
        rx(8'hb0, {2'b10, 8'h33, 1'b0}, 11, 8'hb0);
        rx(8'hb0, {2'b11, 8'h5a, 1'b0}, 11, 8'hb5);
        rx(8'hb0, {2'b11, 8'hff, 1'b0}, 11, 8'hb5);
        rx(8'hb0, {2'b11, 8'h5b, 1'b0}, 11, 8'hb0);
        rx(8'h90, {2'b10, d, 1'b0}, 11, 8'h91);
        rx(8'h80, {2'b11, d, 1'b0}, 11, 8'h80);
        bc = 16'h0020;
        rx(8'hd0, {2'b01, d, 1'b0}, 11, 8'hd5);
        rx(8'h50, {2'b01, d, 1'b0}, 10, 8'h55);
        rx(8'h70, {2'b00, 8'h5a, 1'b0}, 10, 8'h70);
        rx(8'h70, {2'b01, 8'h5a, 1'b0}, 10, 8'h71);
        apb(1'b1, spl_pkg::OFS_PWR, 8'hc0);
        rd(spl_pkg::OFS_CTRL, 8'hf1);
        on = 1'b0;
        apb(1'b1, spl_pkg::OFS_PWR, 8'h00);
        apb(1'b1, spl_pkg::OFS_CTRL, 8'h20);
        apb(1'b1, spl_pkg::OFS_DATA, 8'($urandom));
        repeat (20) @(posedge SYS_CLK);
        rd(spl_pkg::OFS_ISTAT, 8'h06);
        repeat (20) @(posedge SYS_CLK);
        rd(spl_pkg::OFS_ISTAT, 8'h07);
        apb(1'b1, spl_pkg::OFS_IMASK, 8'h00);
        print_verdict();
    end
endmodule // tb_top
